// ===== sbs_ctl_model.sv
// controller-side clock source for the input and output clock pairs
`timescale 1ns/10ps
module sbs_ctl_model (
   input  wire logic run,     // clocks toggle while high
   input  wire logic single,  // hold both output clocks high
   output logic      k_clk,   // positive input clock
   output logic      k_n_clk, // negative input clock
   output logic      c_clk,   // positive output clock
   output logic      c_n_clk  // negative output clock
);
   logic ph;
   // ------------------------------------------------------------
   // clock generation
   // ------------------------------------------------------------
   // 160 ns period, phase offset from core clock; parks low when stopped
   initial begin
      ph = 1'b0;
      #1.3;
      forever begin
         #80;
         ph = run ? ~ph : 1'b0;
      end
   end
   // one bank only, so the single load strobe is never shared
   assign k_clk   = ph;
   assign k_n_clk = ~ph;
   // both output clocks high selects the single-clock strap
   assign c_clk   = single | ph;
   assign c_n_clk = single | ~ph;
endmodule : sbs_ctl_model

// ===== sbs_defs.svh
// constants for the separate-io burst sram port
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_AW         20
`define SBS_WAW        21
`define SBS_DW         18
`define SBS_BW         9
`define SBS_NB         2
`define SBS_CLK_NS     5
`define SBS_STALL_NS   30
`define SBS_STALL_CYC  ((`SBS_STALL_NS + `SBS_CLK_NS - 1) / `SBS_CLK_NS)
`define SBS_LOCK_CYC   1024
`define SBS_RECAL_CYC  1024
`define SBS_CNT_W      11
`define SBS_STRAP_WAIT 2'h3
`endif

// ===== sbs_pkg.sv
// types shared by the separate-io burst sram port
`include "sbs_defs.svh"
package sbs_pkg;
   // delay-locked loop states
   typedef enum logic [1:0] {
      SBS_DLL_OFF,
      SBS_DLL_WAIT,
      SBS_DLL_LOCK
   } sbs_dll_e;

   // one latched access request
   typedef struct packed {
      logic              valid;
      logic [`SBS_AW-1:0] addr;
   } sbs_req_s;

   // one held write word awaiting the array
   typedef struct packed {
      logic               valid;
      logic [`SBS_WAW-1:0] waddr;
      logic [`SBS_DW-1:0]  data;
      logic [`SBS_NB-1:0]  bws_n;
   } sbs_post_s;
endpackage : sbs_pkg

// ===== sbs_sram.sv
// separate-io two-word burst sram: command, array, output and loop logic
// ----------------------------------------------------------------------------
// What this block does
// - accesses start on positive input clock rise; controls registered there only
// - write data captured on rises of both input clocks
// - read data leaves output registers on output clocks, or input clocks
// - read high with load low stores address in read address register
// - word A+0 on the negative output rise after the next positive input rise, word A+1 on the positive output rise after that
// - a new read may start on every positive input clock rise
// - without read, finish pending burst then float read outputs
// - read low with load low stores address in write address register
// - first word on next positive rise, second on next negative rise
// - a new write may start on every positive input clock rise
// - when not selected, finish pending write then ignore inputs
// - byte selects sampled per word; deasserted byte keeps stored value
// - both output clocks high at power on picks single-clock mode
// - two free-running echo clocks follow the output clock pair, or the input pair in single-clock mode
// - write before read is held and committed at the next free slot
// - output impedance recalibrates every 1024 cycles
// - loop locks 1024 input clocks after a stable clock
// - input clocks stalled 30 ns or more reset the loop
// - loop disable low turns the loop off
// - burst words map to address A and A plus one
// - comes up deselected with read outputs floating
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "sbs_defs.svh"
module sbs_sram #(
   parameter int STALL_CYC = `SBS_STALL_CYC
) (
   input  wire logic                clk,                    // core clock, 200 MHz
   input  wire logic                rst,                    // async reset, high
   input  wire logic                k_clk,                  // positive input clock
   input  wire logic                k_n_clk,                // negative input clock
   input  wire logic                c_clk,                  // positive output clock
   input  wire logic                c_n_clk,                // negative output clock
   input  wire logic                load_strobe_n,          // access request, low
   input  wire logic                rw_sel,                 // high read, low write
   input  wire logic [`SBS_NB-1:0]  byte_write_select_n,    // byte enables, low
   input  wire logic [`SBS_AW-1:0]  addr,                   // burst address
   input  wire logic [`SBS_DW-1:0]  wdata,                  // write data word
   input  wire logic                loop_disable_n,         // low turns loop off
   output logic      [`SBS_DW-1:0]  rdata,                  // read data word
   output logic                     rdata_oe,               // read outputs driven
   output logic                     echo_out_clock,         // echo of positive clock
   output logic                     echo_out_clock_n,       // echo of negative clock
   output logic                     dll_locked,             // loop locked
   output logic                     impedance_recal         // recalibration pulse
);

   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------

   // byte-masked merge of new data into stored word
   function automatic logic [`SBS_DW-1:0] sbs_merge(
      input logic [`SBS_DW-1:0] old_w,
      input logic [`SBS_DW-1:0] new_w,
      input logic [`SBS_NB-1:0] bws_n
   );
      logic [`SBS_DW-1:0] res;
      res = old_w;
      for (int b = 0; b < `SBS_NB; b++) begin
         if (!bws_n[b]) begin
            res[b*`SBS_BW +: `SBS_BW] = new_w[b*`SBS_BW +: `SBS_BW];
         end
      end
      return res;
   endfunction : sbs_merge

   // ------------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------------
   logic [`SBS_DW-1:0]   mem [0:(1 << `SBS_WAW) - 1];
   sbs_pkg::sbs_req_s    rd_req_r;
   sbs_pkg::sbs_req_s    wr_req_r;
   sbs_pkg::sbs_post_s   post_r;
   logic                 wr_ph_r;
   logic [`SBS_AW-1:0]   wr_a1_r;
   logic [`SBS_DW-1:0]   kn_data_r;
   logic [`SBS_NB-1:0]   kn_bws_r;
   logic                 rd_valid_r;
   logic [`SBS_DW-1:0]   rd_w0_r;
   logic [`SBS_DW-1:0]   rd_w1_r;
   logic [`SBS_DW-1:0]   rd_w1_nxt;
   logic                 commit;
   logic                 oclk;
   logic                 oclk_n;
   logic [`SBS_DW-1:0]   q_lo_r;
   logic [`SBS_DW-1:0]   q_hi_r;
   logic [`SBS_DW-1:0]   hi_hold_r;
   logic                 oe_lo_r;
   logic                 oe_hi_r;
   logic                 kt_r;
   logic [1:0]           sm_k_r;
   logic [1:0]           c_s_r;
   logic [1:0]           cn_s_r;
   logic [1:0]           loop_disable_n_s_r;
   logic [2:0]           kt_s_r;
   logic                 k_edge;
   logic [1:0]           strap_cnt_r;
   logic                 strap_done_r;
   logic                 single_mode_r;
   sbs_pkg::sbs_dll_e    dll_r;
   logic [`SBS_CNT_W-1:0] lock_cnt_r;
   logic [7:0]           stall_cnt_r;
   logic                 stalled;
   logic [`SBS_CNT_W-1:0] recal_cnt_r;
   logic                 recal_r;
   logic                 locked_r;

   // ------------------------------------------------------------------------
   // command capture on positive input clock
   // ------------------------------------------------------------------------

   // load strobe and select only matter at positive input clock rise
   always_ff @(posedge k_clk or posedge rst) begin
      if (rst) begin
         rd_req_r <= '0;
         wr_req_r <= '0;
      end else begin
         rd_req_r.valid <= !load_strobe_n && rw_sel;
         rd_req_r.addr  <= addr;
         wr_req_r.valid <= !load_strobe_n && !rw_sel;
         wr_req_r.addr  <= addr;
      end
   end

   // write data phase: word A+0 on this rise, A+1 waits for negative rise
   always_ff @(posedge k_clk or posedge rst) begin
      if (rst) begin
         wr_ph_r <= 1'b0;
         wr_a1_r <= '0;
      end else begin
         wr_ph_r <= wr_req_r.valid;
         wr_a1_r <= wr_req_r.addr;
      end
   end

   // second write word captured on negative input clock rise
   always_ff @(posedge k_n_clk or posedge rst) begin
      if (rst) begin
         kn_data_r <= '0;
         kn_bws_r  <= '1;
      end else begin
         kn_data_r <= wdata;
         kn_bws_r  <= byte_write_select_n;
      end
   end

   // ------------------------------------------------------------------------
   // posted write register
   // ------------------------------------------------------------------------

   // held word goes to the array on a free rise, or when a newer word arrives
   assign commit = post_r.valid && (!rd_req_r.valid || wr_ph_r);

   // park the second word; a fetch in flight keeps it parked
   always_ff @(posedge k_clk or posedge rst) begin
      if (rst) begin
         post_r <= '0;
      end else if (wr_ph_r) begin
         post_r.valid <= 1'b1;
         post_r.waddr <= {wr_a1_r, 1'b1};
         post_r.data  <= kn_data_r;
         post_r.bws_n <= kn_bws_r;
      end else if (commit) begin
         post_r.valid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // array
   // ------------------------------------------------------------------------

   // word A+0 written at the rise after the command; held word when free
   always_ff @(posedge k_clk) begin
      if (wr_req_r.valid) begin
         mem[{wr_req_r.addr, 1'b0}] <= sbs_merge(mem[{wr_req_r.addr, 1'b0}], wdata,
                                                 byte_write_select_n);
      end
      if (commit) begin
         mem[post_r.waddr] <= sbs_merge(mem[post_r.waddr], post_r.data,
                                        post_r.bws_n);
      end
   end

   // word A+1 with the held word and the just-arrived word applied on top
   always_comb begin
      rd_w1_nxt = mem[{rd_req_r.addr, 1'b1}];
      if (post_r.valid && post_r.waddr == {rd_req_r.addr, 1'b1}) begin
         rd_w1_nxt = sbs_merge(rd_w1_nxt, post_r.data, post_r.bws_n);
      end
      if (wr_ph_r && wr_a1_r == rd_req_r.addr) begin
         rd_w1_nxt = sbs_merge(rd_w1_nxt, kn_data_r, kn_bws_r);
      end
   end

   // read fetch one rise after the command, held word forwarded
   always_ff @(posedge k_clk or posedge rst) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_w0_r    <= '0;
         rd_w1_r    <= '0;
      end else begin
         rd_valid_r <= rd_req_r.valid;
         if (rd_req_r.valid) begin
            rd_w0_r <= mem[{rd_req_r.addr, 1'b0}];
            rd_w1_r <= rd_w1_nxt;
         end
      end
   end

   // ------------------------------------------------------------------------
   // output registers and echo clocks
   // ------------------------------------------------------------------------

   // strap level carried into the input clock domain
   always_ff @(posedge k_clk or posedge rst) begin
      if (rst) begin
         sm_k_r <= 2'h0;
      end else begin
         sm_k_r <= {sm_k_r[0], single_mode_r};
      end
   end

   // output clock pair, or input pair in single-clock mode
   assign oclk             = sm_k_r[1] ? k_clk : c_clk;
   assign oclk_n           = sm_k_r[1] ? k_n_clk : c_n_clk;
   assign echo_out_clock   = oclk;
   assign echo_out_clock_n = oclk_n;

   // negative output rise: word A+0 out, A+1 staged
   always_ff @(posedge oclk_n or posedge rst) begin
      if (rst) begin
         q_lo_r    <= '0;
         hi_hold_r <= '0;
         oe_lo_r   <= 1'b0;
      end else begin
         q_lo_r    <= rd_w0_r;
         hi_hold_r <= rd_w1_r;
         oe_lo_r   <= rd_valid_r;
      end
   end

   // positive output rise: word A+1 out
   always_ff @(posedge oclk or posedge rst) begin
      if (rst) begin
         q_hi_r  <= '0;
         oe_hi_r <= 1'b0;
      end else begin
         q_hi_r  <= hi_hold_r;
         oe_hi_r <= oe_lo_r;
      end
   end

   // each half of the output clock shows the register of its own edge
   assign rdata    = oclk ? q_hi_r : q_lo_r;
   assign rdata_oe = oclk ? oe_hi_r : oe_lo_r;

   // ------------------------------------------------------------------------
   // core clock: synchronisers and strap
   // ------------------------------------------------------------------------

   // input clock activity toggle
   always_ff @(posedge k_clk or posedge rst) begin
      if (rst) begin
         kt_r <= 1'b0;
      end else begin
         kt_r <= !kt_r;
      end
   end

   // two-flop synchronisers for pins and the activity toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         c_s_r    <= 2'h0;
         cn_s_r   <= 2'h0;
         loop_disable_n_s_r <= 2'h0;
         kt_s_r   <= 3'h0;
      end else begin
         c_s_r    <= {c_s_r[0], c_clk};
         cn_s_r   <= {cn_s_r[0], c_n_clk};
         loop_disable_n_s_r <= {loop_disable_n_s_r[0], loop_disable_n};
         kt_s_r   <= {kt_s_r[1:0], kt_r};
      end
   end

   assign k_edge = kt_s_r[2] ^ kt_s_r[1];

   // strap caught once, after synchronisers settle, then frozen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_cnt_r   <= 2'h0;
         strap_done_r  <= 1'b0;
         single_mode_r <= 1'b0;
      end else if (!strap_done_r) begin
         if (strap_cnt_r == `SBS_STRAP_WAIT) begin
            strap_done_r  <= 1'b1;
            single_mode_r <= c_s_r[1] && cn_s_r[1];
         end else begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // delay-locked loop model and impedance timer
   // ------------------------------------------------------------------------

   // time since the last input clock rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stall_cnt_r <= 8'h00;
      end else if (k_edge) begin
         stall_cnt_r <= 8'h00;
      end else if (stall_cnt_r != 8'hFF) begin
         stall_cnt_r <= stall_cnt_r + 8'h01;
      end
   end

   assign stalled = stall_cnt_r >= 8'(STALL_CYC);

   // lock sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dll_r      <= sbs_pkg::SBS_DLL_OFF;
         lock_cnt_r <= '0;
         locked_r   <= 1'b0;
      end else if (!loop_disable_n_s_r[1]) begin
         dll_r      <= sbs_pkg::SBS_DLL_OFF;
         lock_cnt_r <= '0;
         locked_r   <= 1'b0;
      end else begin
         case (dll_r)
            sbs_pkg::SBS_DLL_OFF: begin
               dll_r      <= sbs_pkg::SBS_DLL_WAIT;
               lock_cnt_r <= '0;
            end
            sbs_pkg::SBS_DLL_WAIT: begin
               if (stalled) begin
                  lock_cnt_r <= '0;
               end else if (k_edge) begin
                  if (lock_cnt_r == `SBS_CNT_W'(`SBS_LOCK_CYC - 1)) begin
                     dll_r    <= sbs_pkg::SBS_DLL_LOCK;
                     locked_r <= 1'b1;
                  end else begin
                     lock_cnt_r <= lock_cnt_r + 1'b1;
                  end
               end
            end
            sbs_pkg::SBS_DLL_LOCK: begin
               if (stalled) begin
                  dll_r      <= sbs_pkg::SBS_DLL_WAIT;
                  lock_cnt_r <= '0;
                  locked_r   <= 1'b0;
               end
            end
            default: begin
               dll_r    <= sbs_pkg::SBS_DLL_OFF;
               locked_r <= 1'b0;
            end
         endcase
      end
   end

   assign dll_locked = locked_r;

   // periodic impedance update strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         recal_cnt_r <= '0;
         recal_r     <= 1'b0;
      end else if (recal_cnt_r == `SBS_CNT_W'(`SBS_RECAL_CYC - 1)) begin
         recal_cnt_r <= '0;
         recal_r     <= 1'b1;
      end else begin
         recal_cnt_r <= recal_cnt_r + 1'b1;
         recal_r     <= 1'b0;
      end
   end

   assign impedance_recal = recal_r;

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------

   rd_addr_a : assert property (@(posedge k_clk) disable iff (rst)
      (!load_strobe_n && rw_sel) |=> rd_req_r.valid && rd_req_r.addr == $past(addr))
      else $error("read address not stored");

   wr_addr_a : assert property (@(posedge k_clk) disable iff (rst)
      (!load_strobe_n && !rw_sel) |=> wr_req_r.valid && wr_req_r.addr == $past(addr))
      else $error("write address not stored");

   rd_fetch_a : assert property (@(posedge k_clk) disable iff (rst)
      (!load_strobe_n && rw_sel) |-> ##2 rd_valid_r)
      else $error("read burst not fetched");

   wr_post_a : assert property (@(posedge k_clk) disable iff (rst)
      wr_req_r.valid |-> ##2 (post_r.valid && post_r.waddr == {$past(wr_req_r.addr, 2), 1'b1}))
      else $error("second write word not held");

   idle_cmd_a : assert property (@(posedge k_clk) disable iff (rst)
      load_strobe_n |=> !rd_req_r.valid && !wr_req_r.valid ##1 !wr_ph_r && !rd_valid_r)
      else $error("deselected cycle started an access");

   post_hold_a : assert property (@(posedge k_clk) disable iff (rst)
      (post_r.valid && rd_req_r.valid && !wr_ph_r) |=> post_r.valid && $stable(post_r.waddr))
      else $error("posted write lost during read");

   dll_lock_a : assert property (@(posedge clk) disable iff (rst)
      $rose(locked_r) |-> $past(lock_cnt_r) == `SBS_CNT_W'(`SBS_LOCK_CYC - 1))
      else $error("loop locked early");

   dll_stall_a : assert property (@(posedge clk) disable iff (rst)
      (stalled && loop_disable_n_s_r[1]) |=> !locked_r)
      else $error("loop kept lock on stalled clock");

   dll_off_a : assert property (@(posedge clk) disable iff (rst)
      !loop_disable_n_s_r[1] |=> dll_r == sbs_pkg::SBS_DLL_OFF && !locked_r)
      else $error("loop not off when disabled");

   recal_a : assert property (@(posedge clk) disable iff (rst)
      recal_r |-> recal_cnt_r == '0 ##1 !recal_r [*8])
      else $error("impedance update out of period");

   strap_a : assert property (@(posedge clk) disable iff (rst)
      strap_done_r |=> strap_done_r && $stable(single_mode_r))
      else $error("clock strap changed");

   rd_burst_c : cover property (@(posedge k_clk) disable iff (rst)
      rd_req_r.valid ##1 rd_valid_r);

   wr_burst_c : cover property (@(posedge k_clk) disable iff (rst)
      wr_req_r.valid ##1 wr_ph_r ##1 post_r.valid);

   posted_c : cover property (@(posedge k_clk) disable iff (rst)
      wr_ph_r && rd_req_r.valid ##1 post_r.valid && rd_req_r.valid);

   locked_c : cover property (@(posedge clk) disable iff (rst) $rose(locked_r));

endmodule : sbs_sram

// ===== sbs_sram_test.sv
// self-checking bench for the separate-io burst sram port
`timescale 1ns/10ps
`include "sbs_defs.svh"
`define SBS_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module sbs_sram_test;
   logic clk, rst, run, single, load_strobe_n, rw_sel, loop_disable_n;
   logic k_clk, k_n_clk, c_clk, c_n_clk, rdata_oe, echo_out_clock, echo_out_clock_n;
   logic dll_locked, impedance_recal;
   logic [`SBS_NB-1:0] byte_write_select_n;
   logic [`SBS_AW-1:0] addr;
   logic [`SBS_DW-1:0] wdata, rdata, q0, q1, q2;
   logic [`SBS_DW-1:0] mem [0:31];
   logic pv = 1'b0, prw = 1'b0, wv = 1'b0, r1 = 1'b0, r2 = 1'b0, wp = 1'b0;
   logic [3:0]  pa = 4'h0, wb = 4'hF;
   logic [4:0]  wa;
   logic [35:0] wd;
   logic [63:0] rv;
   int seed = 32'h041AC4B9;
   int total_checks = 0, miscompares = 0, rc = 0, np = 0;

   sbs_sram #(.STALL_CYC(40)) dut (.clk(clk), .rst(rst), .k_clk(k_clk), .k_n_clk(k_n_clk),
      .c_clk(c_clk), .c_n_clk(c_n_clk), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel),
      .byte_write_select_n(byte_write_select_n), .addr(addr), .wdata(wdata),
      .loop_disable_n(loop_disable_n), .rdata(rdata), .rdata_oe(rdata_oe),
      .echo_out_clock(echo_out_clock), .echo_out_clock_n(echo_out_clock_n),
      .dll_locked(dll_locked), .impedance_recal(impedance_recal));
   sbs_ctl_model ctl (.run(run), .single(single), .k_clk(k_clk), .k_n_clk(k_n_clk),
      .c_clk(c_clk), .c_n_clk(c_n_clk));

   // ------------------------------------------------------------
   // expectation model
   // ------------------------------------------------------------
   // byte merge of a new word over the stored one
   function automatic logic [17:0] merge(input logic [17:0] o, n, input logic [1:0] b);
      merge = {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
   endfunction : merge

   // word0 commit, read fetch and command capture at each input clock rise
   always @(posedge k_clk) begin
      wv = pv & ~prw;
      wa = {pa, 1'b1};
      if (wv) mem[{pa, 1'b0}] = merge(mem[{pa, 1'b0}], wdata, byte_write_select_n);
      r2 = r1;
      q2 = q1;
      r1 = pv & prw;
      if (r1) {q0, q1} = {mem[{pa, 1'b0}], mem[{pa, 1'b1}]};
      pv = ~load_strobe_n;
      prw = rw_sel;
      pa = addr[3:0];
      #2;
      `SBS_CHK(rdata_oe, r2)
      if (r2) `SBS_CHK(rdata, q2)
      `SBS_CHK(echo_out_clock, 1'b1)
   end

   // word1 commit and first read word at each negative clock rise
   always @(posedge k_n_clk) begin
      if (wv) mem[wa] = merge(mem[wa], wdata, byte_write_select_n);
      wv = 1'b0;
      #2;
      `SBS_CHK(rdata_oe, r1)
      if (r1) `SBS_CHK(rdata, q0)
      if (!single) `SBS_CHK(echo_out_clock, 1'b0)
      `SBS_CHK(echo_out_clock_n, 1'b1)
   end

   // spacing of impedance recalibration pulses
   always @(posedge clk) begin
      rc = rst ? 0 : rc + 1;
      if (impedance_recal && np++ > 0) `SBS_CHK(rc, 1024)
      if (impedance_recal) rc = 0;
   end

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   // one input clock period: command plus the words of the previous write
   task automatic slot(input logic ld, rw, input logic [3:0] a, input logic [35:0] d,
                       input logic [3:0] b);
      @(posedge k_n_clk);
      @(posedge clk);
      load_strobe_n <= ~ld;
      rw_sel <= rw;
      addr <= {16'h0000, a};
      wdata <= wp ? wd[17:0] : ~wdata;
      byte_write_select_n <= wp ? wb[1:0] : 2'h3;
      @(posedge k_clk);
      @(posedge clk);
      wdata <= wp ? wd[35:18] : ~wdata;
      byte_write_select_n <= wp ? wb[3:2] : 2'h3;
      wp = ld & ~rw;
      wd = d;
      wb = b;
   endtask : slot

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   always #2.5 clk = ~clk;

   // watchdog well past the expected run length
   initial begin
      #400000;
      miscompares++;
      test_done();
   end

   // main sequence
   initial begin
      {clk, rst, run, single, load_strobe_n, rw_sel, addr, wdata} = {4'h6, 2'h2, 38'h0};
      byte_write_select_n = 2'h3;
      loop_disable_n = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      `SBS_CHK(dll_locked, 1'b0)
      for (int i = 0; i < 16; i++) begin
         rv = {$random(seed), $random(seed)};
         slot(1'b1, 1'b0, i[3:0], rv[35:0], 4'h0);
      end
      for (int i = 0; i < 300; i++) begin
         rv = {$random(seed), $random(seed)};
         slot(rv[63:62] != 2'h0, rv[61], rv[59:56], rv[35:0], rv[55:52]);
      end
      slot(1'b1, 1'b0, 4'h5, 36'h2AAAA5555, 4'h6);
      slot(1'b1, 1'b1, 4'h5, 36'h0, 4'hF);
      slot(1'b0, 1'b0, 4'h0, 36'h0, 4'hF);
      repeat (720) @(posedge k_clk);
      #20 `SBS_CHK(dll_locked, 1'b1)
      run = 1'b0;
      #400 `SBS_CHK(dll_locked, 1'b0)
      run = 1'b1;
      repeat (1030) @(posedge k_clk);
      #20 `SBS_CHK(dll_locked, 1'b1)
      @(posedge clk) loop_disable_n <= 1'b0;
      repeat (4) @(posedge clk);
      `SBS_CHK(dll_locked, 1'b0)
      `SBS_CHK(np > 10, 1'b1)
      @(posedge clk) {rst, single} <= 2'h3;
      repeat (2) @(posedge k_clk);
      @(posedge clk) rst <= 1'b0;
      repeat (4) @(posedge k_clk);
      @(posedge k_n_clk);
      #2 `SBS_CHK(echo_out_clock, 1'b0)
      test_done();
   end
endmodule : sbs_sram_test
